// File: bench/sdram_mem_model.sv
// sdram array of four double words with read error injection
`timescale 1ns/1ps
module sdram_mem_model (
    // clock
    input wire logic i_clk_sys,
    // beat control from the datapath
    input wire logic i_mem_beat,
    input wire logic i_mem_we,
    input wire logic [1:0] i_mem_dw,
    input wire logic [7:0] i_mem_dqm,
    input wire logic [63:0] i_mem_wdata,
    input wire logic [7:0] i_check_bit_lines,
    input wire logic i_check_bit_lines_oe_n,
    // bits flipped on every read beat
    input wire logic [63:0] i_flip,
    // read return
    output logic [63:0] o_mem_rdata = '0,
    output logic [7:0] o_check_bit_lines = '0
);
    logic [63:0] data_q [4];
    logic [7:0] chk_q [4];
    always @(posedge i_clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (i_mem_beat && i_mem_we && !i_mem_dqm[i]) begin
                data_q[i_mem_dw][8*i +: 8] <= i_mem_wdata[8*i +: 8];
                if (!i_check_bit_lines_oe_n) begin
                    chk_q[i_mem_dw][i] <= i_check_bit_lines[i];
                end
            end
        end
        // toggle outside reads so stale data never matches
        if (i_mem_beat && !i_mem_we) begin
            o_mem_rdata <= data_q[i_mem_dw] ^ i_flip;
            o_check_bit_lines <= chk_q[i_mem_dw];
        end else begin
            o_mem_rdata <= ~o_mem_rdata;
            o_check_bit_lines <= ~o_check_bit_lines;
        end
    end
endmodule

// File: bench/tb.sv
// bench for the sdram ecc datapath
`timescale 1ns/1ps
module tb;
    import sdram_ecc_pkg::*;
    localparam logic [31:0] ECC_ON = 32'h15;
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0;
    logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
    logic i_rready = 0, i_req_valid = 0, i_req_write = 0, i_req_single = 0;
    logic [31:0] i_wdata = '0, o_rdata;
    logic [3:0] i_wstrb = '0;
    logic [1:0] i_req_dw = '0, o_bresp, o_rresp, o_rd_dw, o_mem_dw;
    logic [1:0] wptr = '0;
    logic [7:0] i_req_be = '0, i_req_wpar, i_check_bit_lines;
    logic [7:0] o_rd_par, o_mem_dqm, o_check_bit_lines;
    logic [63:0] i_req_wdata, i_mem_rdata, o_rd_data, o_mem_wdata;
    logic [63:0] flip = '0;
    logic [63:0] wbuf [4] = '{default: '0};
    logic [63:0] image [4];
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_req_ready;
    logic o_wr_take, o_rd_valid, o_rd_err, o_done, o_mem_beat, o_mem_we;
    logic o_check_bit_lines_oe_n, o_irq;
    logic [66:0] exp_rd [$], exp_beat [$], exp_r [$], exp_b [$];
    int miscompares = 0, n_tests = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    function automatic logic [7:0] par8(input logic [63:0] d);
        for (int i = 0; i < 8; i++) par8[i] = ^d[8*i +: 8];
    endfunction

    assign i_req_wdata = wbuf[wptr];
    assign i_req_wpar = par8(i_req_wdata);
    always @(posedge i_clk_sys) if (o_wr_take) wptr <= wptr + 2'd1;

    sdram_ecc_burst_datapath #(.BEATS(BURST_BEATS)) dut_u (.i_clk_sys,
        .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .i_req_valid, .o_req_ready, .i_req_write, .i_req_single, .i_req_dw,
        .i_req_be, .i_req_wdata, .i_req_wpar, .o_wr_take, .o_rd_valid,
        .o_rd_data, .o_rd_dw, .o_rd_par, .o_rd_err, .o_done, .o_mem_beat,
        .o_mem_we, .o_mem_dw, .o_mem_dqm, .o_mem_wdata, .i_mem_rdata,
        .o_check_bit_lines, .o_check_bit_lines_oe_n, .i_check_bit_lines,
        .o_irq);
    sdram_mem_model mem_u (.i_clk_sys, .i_mem_beat(o_mem_beat),
        .i_mem_we(o_mem_we), .i_mem_dw(o_mem_dw), .i_mem_dqm(o_mem_dqm),
        .i_mem_wdata(o_mem_wdata), .i_check_bit_lines(o_check_bit_lines),
        .i_check_bit_lines_oe_n(o_check_bit_lines_oe_n), .i_flip(flip),
        .o_mem_rdata(i_mem_rdata), .o_check_bit_lines(i_check_bit_lines));

    task automatic stop_test(input logic hung);
        if (hung) miscompares++;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [66:0] e, got);
        n_tests++;
        if (got !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, e, got);
        end
    endtask

    // compare each result with its oldest note
    always @(posedge i_clk_sys) begin
        logic [66:0] e;
        if (o_mem_beat) begin
            e = exp_beat.size() ? exp_beat.pop_front() : 'x;
            chk("mem beat", e, {o_mem_we, o_mem_dw, o_mem_dqm});
        end
        if (o_rd_valid) begin
            e = exp_rd.size() ? exp_rd.pop_front() : 'x;
            chk("rd err dw", e[66:64], {o_rd_err, o_rd_dw});
            if (e[66] === 1'b0) begin
                chk("rd data", e[63:0], o_rd_data);
                chk("rd parity", par8(e[63:0]), o_rd_par);
            end
        end
        if (o_rvalid && i_rready) begin
            e = exp_r.size() ? exp_r.pop_front() : 'x;
            chk("reg read", e, {o_rresp, o_rdata});
        end
        if (o_bvalid && i_bready) begin
            e = exp_b.size() ? exp_b.pop_front() : 'x;
            chk("bresp", e, o_bresp);
        end
    end

    task automatic reg_op(input logic wr, input logic [7:0] idx,
                          input logic [31:0] d, input logic [1:0] resp);
        int n = 0;
        if (wr) exp_b.push_back(resp);
        else exp_r.push_back({resp, d});
        i_awaddr <= {2'b00, idx, 2'b00};
        i_araddr <= {2'b00, idx, 2'b00};
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_awvalid <= wr;
        i_wvalid <= wr;
        i_bready <= wr;
        i_arvalid <= !wr;
        i_rready <= !wr;
        do begin
            @(posedge i_clk_sys);
            n++;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) i_bready <= 1'b0;
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) i_rready <= 1'b0;
        end while ((i_awvalid || i_wvalid || i_bready || i_arvalid
                    || i_rready) && n < 100);
        if (n >= 100) stop_test(1'b1);
    endtask

    task automatic exp_burst(input logic we, single, input logic [1:0] dw,
                             input logic [7:0] dqm0);
        for (int k = 0; k < 4; k++)
            exp_beat.push_back({we, dw + 2'(k),
                (k == 0) ? dqm0 : (single ? 8'hff : 8'h00)});
    endtask

    task automatic mem_req(input logic wr, single, input logic [1:0] dw,
                           input logic [7:0] be);
        int n = 0;
        wptr <= '0;
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_single <= single;
        i_req_dw <= dw;
        i_req_be <= be;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (!o_req_ready && n < 50);
        i_req_valid <= 1'b0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_done !== 1'b1 && n < 200);
        if (n >= 200) stop_test(1'b1);
    endtask

    task automatic sread(input logic [1:0] dw, input logic [63:0] d,
                         input logic err);
        exp_burst(1'b0, 1'b1, dw, 8'h00);
        exp_rd.push_back({err, dw, d});
        mem_req(1'b0, 1'b1, dw, 8'hff);
    endtask

    initial begin
        int b;
        logic [63:0] w;
        void'($urandom(75521));
        repeat (20) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        reg_op(0, IDX_CTRL, 32'(CTRL_RST), RESP_OKAY);
        reg_op(0, IDX_SBE_TRIG, 32'(SBE_TRIG_RST), RESP_OKAY);
        reg_op(0, 8'h40, 32'h0, RESP_SLVERR);
        reg_op(1, 8'h40, 32'h1, RESP_SLVERR);
        $display("test registers done");
        reg_op(1, IDX_CTRL, ECC_ON, RESP_OKAY);
        reg_op(1, IDX_INT_EN, 32'h3, RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            w = {$urandom, $urandom};
            wbuf[k] <= w;
            image[(2 + k) % 4] = w;
        end
        exp_burst(1'b1, 1'b0, 2'd2, 8'h00);
        mem_req(1'b1, 1'b0, 2'd2, 8'hff);
        exp_burst(1'b0, 1'b0, 2'd1, 8'h00);
        for (int k = 0; k < 4; k++)
            exp_rd.push_back({1'b0, 2'(1 + k), image[(1 + k) % 4]});
        mem_req(1'b0, 1'b0, 2'd1, 8'hff);
        $display("test bursts done");
        sread(2'd2, image[2], 1'b0);
        reg_op(1, IDX_SBE_TRIG, 32'h2, RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            flip <= 64'h1 << ($urandom % 64);
            sread(2'd3, image[3], 1'b0);
            reg_op(0, IDX_STATUS, 32'(k), RESP_OKAY);
        end
        reg_op(0, IDX_SBE_COUNT, 32'h2, RESP_OKAY);
        chk("irq", 1'b1, o_irq);
        reg_op(1, IDX_INT_EN, 32'h2, RESP_OKAY);
        chk("irq masked", 1'b0, o_irq);
        b = $urandom % 16;
        flip <= 64'h3 << (4 * b);
        sread(2'd0, image[0], 1'b1);
        reg_op(0, IDX_STATUS, 32'h3, RESP_OKAY);
        chk("irq", 1'b1, o_irq);
        reg_op(1, IDX_INT_CLR, 32'h3, RESP_OKAY);
        reg_op(0, IDX_STATUS, 32'h0, RESP_OKAY);
        chk("irq cleared", 1'b0, o_irq);
        $display("test error reporting done");
        flip <= '0;
        w = {$urandom, $urandom};
        for (int k = 0; k < 4; k++) wbuf[k] <= w;
        image[1][31:0] = w[31:0];
        exp_burst(1'b0, 1'b1, 2'd1, 8'h00);
        exp_burst(1'b1, 1'b1, 2'd1, 8'h00);
        mem_req(1'b1, 1'b1, 2'd1, 8'h0f);
        sread(2'd1, image[1], 1'b0);
        $display("test partial write done");
        reg_op(1, IDX_CTRL, 32'h5, RESP_OKAY);
        b = $urandom % 64;
        flip <= 64'h1 << b;
        sread(2'd0, image[0] ^ (64'h1 << b), 1'b0);
        reg_op(0, IDX_STATUS, 32'h0, RESP_OKAY);
        $display("test ecc off done");
        stop_test(1'b0);
    end
endmodule

// File: src/sdram_ecc_burst_datapath.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// ecc, parity and burst sequencing to sdram
module sdram_ecc_burst_datapath
    import sdram_ecc_pkg::*;
#(
    parameter int BEATS = BURST_BEATS
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // axi4-lite register slave
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // processor request side
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_write,
    input wire logic i_req_single,
    input wire logic [1:0] i_req_dw,
    input wire logic [7:0] i_req_be,
    input wire logic [63:0] i_req_wdata,
    input wire logic [7:0] i_req_wpar,
    output logic o_wr_take,
    output logic o_rd_valid,
    output logic [63:0] o_rd_data,
    output logic [1:0] o_rd_dw,
    output logic [7:0] o_rd_par,
    output logic o_rd_err,
    output logic o_done,
    // sdram data side
    output logic o_mem_beat,
    output logic o_mem_we,
    output logic [1:0] o_mem_dw,
    output logic [7:0] o_mem_dqm,
    output logic [63:0] o_mem_wdata,
    input wire logic [63:0] i_mem_rdata,
    output logic [7:0] o_check_bit_lines,
    output logic o_check_bit_lines_oe_n,
    input wire logic [7:0] i_check_bit_lines,
    // interrupt
    output logic o_irq
);

    if (BEATS != 4) begin : g_bad_beats
        $error("only four-beat bursts are supported");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_WR, S_TAIL
    } state_e;

    state_e state_q;
    logic [1:0] beat_q, dw_q;
    logic single_q, rmw_q, wr_q;
    logic [7:0] be_q;
    logic [63:0] wbuf_q, rmwbuf_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [ST_W-1:0] status_q, int_en_q, st_set;
    logic [7:0] count_q, trig_q, cnt_inc;
    logic ecc_on, par_on, issue, beat_rel, beat_last, req_fire;
    logic [1:0] beat_idx;
    logic [63:0] merged, beat_wdata, flip, corr;
    logic [7:0] beat_dqm, beat_chk, syn;
    logic data_fix, chk_col, sbe_evt, mbe_evt, mpe_evt, lpe_evt, sbe_rep;
    logic beat_rel_fq, beat_last_fq;
    logic rd_pend_q, rd_rel_q, rd_last_q;
    logic [1:0] rd_idx_q;
    // register bus state
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_wr, wr_hit, wr_lane0;
    logic [7:0] wr_idx, rd_idx;
    logic [31:0] rd_mux;
    logic rd_hit;

    // ecc: in-line, ecc selected, check on, 64-bit bus
    assign ecc_on = ctrl_q[CTRL_INLINE] & ~ctrl_q[CTRL_SEL]
        & ctrl_q[CTRL_CHK_EN] & ctrl_q[CTRL_BUS64];
    assign par_on = ctrl_q[CTRL_INLINE] & ctrl_q[CTRL_SEL];

    assign o_req_ready = (state_q == S_IDLE);
    assign req_fire = i_req_valid & o_req_ready;
    assign issue = (state_q == S_RD) || (state_q == S_WR);
    assign beat_idx = dw_q + beat_q;
    assign beat_rel = !single_q || (beat_q == 2'd0);
    assign beat_last = (beat_q == 2'(BEATS - 1));
    assign o_wr_take = (state_q == S_WR) && !single_q;

    always_comb begin
        for (int i = 0; i < DW_BYTES; i++) begin
            merged[8*i +: 8] = be_q[i] ? wbuf_q[8*i +: 8]
                : rmwbuf_q[8*i +: 8];
        end
    end

    always_comb begin
        if (rmw_q) begin
            beat_wdata = merged;
        end else if (single_q) begin
            beat_wdata = wbuf_q;
        end else begin
            beat_wdata = i_req_wdata;
        end
        if (!beat_rel) begin
            beat_dqm = 8'hff;
        end else if (state_q == S_WR && single_q && !rmw_q) begin
            beat_dqm = ~be_q;
        end else begin
            beat_dqm = 8'h00;
        end
        beat_chk = ecc_on ? gen_check(beat_wdata) : byte_par(beat_wdata);
    end

    // check the beat returned a cycle after issue
    always_comb begin
        syn = i_check_bit_lines ^ gen_check(i_mem_rdata);
        for (int i = 0; i < 64; i++) begin
            flip[i] = (syn == ECC_COL[i]);
        end
        data_fix = |flip;
        chk_col = $onehot(syn);
        corr = ecc_on ? (i_mem_rdata ^ flip) : i_mem_rdata;
    end

    assign sbe_evt = rd_pend_q & rd_rel_q & ecc_on & (data_fix | chk_col);
    assign mbe_evt = rd_pend_q & rd_rel_q & ecc_on & (syn != 8'h00)
        & !(data_fix | chk_col);
    assign mpe_evt = rd_pend_q & rd_rel_q & par_on & ctrl_q[CTRL_CHK_EN]
        & (byte_par(i_mem_rdata) != i_check_bit_lines);
    assign lpe_evt = ctrl_q[CTRL_LPAR_EN]
        & ((req_fire & i_req_write & i_req_single) | o_wr_take)
        & (byte_par(i_req_wdata) != i_req_wpar);
    assign cnt_inc = count_q + 8'd1;
    assign sbe_rep = sbe_evt && (cnt_inc == trig_q);

    assign st_set[ST_SBE] = sbe_rep;
    assign st_set[ST_MBE] = mbe_evt;
    assign st_set[ST_MPE] = mpe_evt;
    assign st_set[ST_LPE] = lpe_evt;
    assign o_irq = |(status_q & int_en_q);

    // transaction sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= S_IDLE;
            beat_q <= 2'd0;
            dw_q <= 2'd0;
            single_q <= 1'b0;
            rmw_q <= 1'b0;
            wr_q <= 1'b0;
            be_q <= 8'h00;
            wbuf_q <= 64'h0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (req_fire) begin
                        dw_q <= i_req_dw;
                        single_q <= i_req_single;
                        wr_q <= i_req_write;
                        be_q <= i_req_single ? i_req_be : 8'hff;
                        wbuf_q <= i_req_wdata;
                        beat_q <= 2'd0;
                        rmw_q <= i_req_write & i_req_single & ecc_on
                            & (i_req_be != 8'hff);
                        if (i_req_write && !(i_req_single && ecc_on
                                && i_req_be != 8'hff)) begin
                            state_q <= S_WR;
                        end else begin
                            state_q <= S_RD;
                        end
                    end
                end
                S_RD, S_WR: begin
                    beat_q <= beat_q + 2'd1;
                    if (beat_last) begin
                        if (state_q == S_RD) begin
                            state_q <= S_TAIL;
                        end else begin
                            state_q <= S_IDLE;
                            o_done <= 1'b1;
                        end
                    end
                end
                S_TAIL: begin
                    if (rd_pend_q && rd_last_q) begin
                        if (rmw_q) begin
                            state_q <= S_WR;
                            beat_q <= 2'd0;
                        end else begin
                            state_q <= S_IDLE;
                            o_done <= 1'b1;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // memory outputs, idle fully masked
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_beat <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_dw <= 2'd0;
            o_mem_dqm <= 8'hff;
            o_mem_wdata <= 64'h0;
            o_check_bit_lines <= 8'h00;
            o_check_bit_lines_oe_n <= 1'b1;
            beat_rel_fq <= 1'b0;
            beat_last_fq <= 1'b0;
        end else begin
            o_mem_beat <= issue;
            o_mem_we <= (state_q == S_WR);
            o_mem_dw <= beat_idx;
            o_mem_dqm <= issue ? beat_dqm : 8'hff;
            o_mem_wdata <= beat_wdata;
            o_check_bit_lines <= beat_chk;
            o_check_bit_lines_oe_n <= !((state_q == S_WR)
                && ctrl_q[CTRL_INLINE]);
            beat_rel_fq <= beat_rel;
            beat_last_fq <= beat_last;
        end
    end

    // read return stage
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_pend_q <= 1'b0;
            rd_rel_q <= 1'b0;
            rd_last_q <= 1'b0;
            rd_idx_q <= 2'd0;
            rmwbuf_q <= 64'h0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 64'h0;
            o_rd_dw <= 2'd0;
            o_rd_par <= 8'h00;
            o_rd_err <= 1'b0;
        end else begin
            rd_pend_q <= o_mem_beat & !o_mem_we;
            rd_rel_q <= beat_rel_fq;
            rd_last_q <= beat_last_fq;
            rd_idx_q <= o_mem_dw;
            if (rd_pend_q && rd_rel_q && rmw_q) begin
                rmwbuf_q <= corr;
            end
            o_rd_valid <= rd_pend_q & rd_rel_q & !rmw_q;
            o_rd_data <= corr;
            o_rd_dw <= rd_idx_q;
            o_rd_par <= byte_par(corr);
            o_rd_err <= mbe_evt | mpe_evt;
        end
    end

    // counter and sticky status, set wins
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= SBE_COUNT_RST;
            status_q <= STATUS_RST;
        end else begin
            if (sbe_evt) begin
                count_q <= cnt_inc;
            end else if (do_wr && wr_hit && wr_lane0
                    && wr_idx == IDX_SBE_COUNT) begin
                count_q <= w_data_q[7:0];
            end
            if (do_wr && wr_hit && wr_lane0 && wr_idx == IDX_INT_CLR) begin
                status_q <= (status_q & ~w_data_q[ST_W-1:0]) | st_set;
            end else begin
                status_q <= status_q | st_set;
            end
        end
    end

    // axi4-lite write channel
    assign o_awready = !aw_have_q && !o_bvalid;
    assign o_wready = !w_have_q && !o_bvalid;
    assign do_wr = aw_have_q && w_have_q && !o_bvalid;
    assign wr_idx = aw_addr_q[9:2];
    assign wr_hit = (aw_addr_q[ADDR_W-1:10] == '0) && (wr_idx inside {
        IDX_CTRL, IDX_STATUS, IDX_INT_CLR,
        IDX_INT_EN, IDX_SBE_COUNT,
        IDX_SBE_TRIG});
    assign wr_lane0 = w_strb_q[0];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RST;
            int_en_q <= INT_EN_RST;
            trig_q <= SBE_TRIG_RST;
        end else if (do_wr && wr_hit && wr_lane0) begin
            if (wr_idx == IDX_CTRL) begin
                ctrl_q <= w_data_q[CTRL_W-1:0];
            end
            if (wr_idx == IDX_INT_EN) begin
                int_en_q <= w_data_q[ST_W-1:0];
            end
            if (wr_idx == IDX_SBE_TRIG) begin
                trig_q <= w_data_q[7:0];
            end
        end
    end

    // axi4-lite read channel
    assign o_arready = !o_rvalid;
    assign rd_idx = i_araddr[9:2];
    assign rd_hit = (i_araddr[ADDR_W-1:10] == '0);

    always_comb begin
        rd_mux = 32'h0;
        case (rd_idx)
            IDX_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
            IDX_STATUS: rd_mux[ST_W-1:0] = status_q;
            IDX_INT_EN: rd_mux[ST_W-1:0] = int_en_q;
            IDX_SBE_COUNT: rd_mux[7:0] = count_q;
            IDX_SBE_TRIG: rd_mux[7:0] = trig_q;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= (rd_hit && (rd_idx inside {IDX_CTRL,
                IDX_STATUS, IDX_INT_CLR, IDX_INT_EN,
                IDX_SBE_COUNT, IDX_SBE_TRIG}))
                ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_burst_four_beats: assert property (
        $rose(o_mem_beat) |-> o_mem_beat [*4] ##1 !o_mem_beat)
        else $error("bad burst length");
    a_critical_first: assert property (
        $rose(o_mem_beat) |-> o_mem_dw == dw_q)
        else $error("critical not first");
    a_wrap_order: assert property (
        o_mem_beat && !beat_last_fq |=> o_mem_dw == 2'($past(o_mem_dw) + 1))
        else $error("bad beat order");
    a_single_mask: assert property (
        o_mem_beat && single_q && o_mem_dw != dw_q |-> o_mem_dqm == 8'hff)
        else $error("beat not masked");
    a_rmw_lanes: assert property (
        o_mem_beat && o_mem_we && rmw_q && o_mem_dw == dw_q
        |-> o_mem_dqm == 8'h00 && gen_check(o_mem_wdata) == o_check_bit_lines)
        else $error("bad merged beat");
    a_check_gen: assert property (
        o_mem_beat && o_mem_we && ecc_on |-> !o_check_bit_lines_oe_n
        && o_check_bit_lines == gen_check(o_mem_wdata))
        else $error("bad check bits");
    a_single_fix: assert property (
        sbe_evt && data_fix && !rmw_q
        |=> o_rd_valid && gen_check(o_rd_data) == $past(i_check_bit_lines))
        else $error("not corrected");
    a_multi_report: assert property (
        mbe_evt |=> status_q[ST_MBE] && o_rd_err)
        else $error("multi-bit unreported");
    a_count_step: assert property (
        sbe_evt |=> count_q == 8'($past(count_q) + 1))
        else $error("bad count step");
    a_trigger_gate: assert property (
        sbe_evt && cnt_inc != trig_q && !status_q[ST_SBE]
        |=> !status_q[ST_SBE])
        else $error("report off trigger");
    a_irq_raise: assert property (
        $rose(status_q[ST_MBE]) && int_en_q[ST_MBE] |-> o_irq)
        else $error("no interrupt");
    a_no_ecc_narrow: assert property (
        !ctrl_q[CTRL_BUS64] || !ctrl_q[CTRL_INLINE] |-> !sbe_evt && !mbe_evt)
        else $error("ecc on narrow bus");

    c_burst_read: cover property (
        $rose(o_mem_beat) && !o_mem_we && !single_q);
    c_rmw_write: cover property (
        o_mem_beat && o_mem_we && rmw_q);
    c_single_fixed: cover property (sbe_evt ##1 status_q[ST_SBE]);
    c_multi_irq: cover property (mbe_evt ##1 o_irq);

endmodule

// File: src/sdram_ecc_pkg.sv
// constants and ecc helpers for the sdram datapath
// Function
// - correct single-bit data errors before returning data
// - no ecc when memory bus is 32 bits
// - detect double-bit errors; some three-bit errors in one nibble pass as single errors
// - always report multi-bit errors, no threshold
// - count single errors, report on trigger match
// - reported memory errors can raise an interrupt
// - memory ecc and local parity enabled separately
// - eight shared check-bit lines carry ecc or parity
// - check ecc on every 64-bit memory read
// - partial ecc writes use read-modify-write
// - eight syndrome bits from data and check
// - every transaction runs as four-beat burst
// - single read masks unrequested beats
// - single write masks all lanes on other beats
// - single-beat bursts never end early
// - critical beat first, wrap modulo four
// - cleared in-line config bits disable memory checking; local parity checking stays on
package sdram_ecc_pkg;

    localparam int ADDR_W = 12;
    localparam int BURST_BEATS = 4;
    localparam int DW_BYTES = 8;

    // register indices, byte address = 4 * index
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_INT_CLR = 8'h02;
    localparam logic [7:0] IDX_INT_EN = 8'h03;
    localparam logic [7:0] IDX_SBE_COUNT = 8'h04;
    localparam logic [7:0] IDX_SBE_TRIG = 8'hb9;

    // control register fields
    localparam int CTRL_INLINE = 0;
    localparam int CTRL_SEL = 1;
    localparam int CTRL_CHK_EN = 2;
    localparam int CTRL_LPAR_EN = 3;
    localparam int CTRL_BUS64 = 4;
    localparam int CTRL_W = 5;

    // status, clear and enable fields
    localparam int ST_SBE = 0;
    localparam int ST_MBE = 1;
    localparam int ST_MPE = 2;
    localparam int ST_LPE = 3;
    localparam int ST_W = 4;

    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
    localparam logic [ST_W-1:0] INT_EN_RST = 4'h0;
    localparam logic [7:0] SBE_COUNT_RST = 8'h00;
    localparam logic [7:0] SBE_TRIG_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // odd-weight columns, weight 3 then 5
    function automatic logic [63:0][7:0] build_cols();
        logic [63:0][7:0] cols;
        int n;
        cols = '0;
        n = 0;
        for (int w = 3; w <= 5; w += 2) begin
            for (int v = 1; v < 256; v++) begin
                if ($countones(v[7:0]) == w && n < 64) begin
                    cols[n] = v[7:0];
                    n++;
                end
            end
        end
        return cols;
    endfunction

    localparam logic [63:0][7:0] ECC_COL = build_cols();

    function automatic logic [7:0] gen_check(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (d[i]) begin
                c = c ^ ECC_COL[i];
            end
        end
        return c;
    endfunction

    function automatic logic [7:0] byte_par(input logic [63:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < DW_BYTES; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction

endpackage
